// [nfc_cmd_read.sv]
// Functional notes
// - erase is 0x20 then 0xd0 confirm
// - bad erase confirm sets bits 4,5, status
// - during erase only status and suspend taken
// - 0xb0 suspends, sets suspend bit and ready
// - suspend holds until 0xd0 resume or reset
// - 0xd0 while suspended resumes operation
// - lock setup needs 0x01/0xd0/0x2f/0x03 else error
// - 0x01 locks block, 0x2f locks down
// - 0xd0 unlocks unless block locked down
// - 0xc0 then write starts protection program
// - 0x60,0x03 loads config from address
// - after config load reads return array
// - reset gives async page, array state
// - four read states, changed by commands
// - async page reads only when mode bit set
// - async reads ignore clock, wait deasserted
// - four-word page, low bits select word
// - burst address latched on adv rise/edge
// - first word after latency, then each edge
// - non-array burst repeats the same word
// - mode bit 0 sync, 1 async default
// - latency counts edges to first word
// - burst length codes 4,8,16,continuous
// - 0xff selects array read state
`include "nfc_params.svh"
module nfc_cmd_read #(
  parameter logic [15:0] MFR_CODE = 16'h00a5, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h005a, // arbitrary value
  parameter logic [7:0] QUERY_BYTE = 8'h00 // query answer byte
) (
  input wire logic core_clk, // system clock, 50 MHz
  input wire logic rstn, // async reset, also device reset pin
  input wire logic [3:0] avs_address, // avalon byte address
  input wire logic avs_read, // avalon read
  input wire logic avs_write, // avalon write
  input wire logic [31:0] avs_writedata, // avalon write data
  input wire logic [3:0] avs_byteenable, // avalon byte enables
  output logic [31:0] avs_readdata, // avalon read data
  output logic avs_waitrequest, // avalon stall
  input wire logic flash_ce_n, // chip enable pin
  input wire logic flash_oe_n, // output enable pin
  input wire logic flash_we_n, // write enable pin
  input wire logic address_valid_n, // address valid pin
  input wire logic flash_clk, // host burst clock pin
  input wire logic [`NFC_ADDR_W-1:0] flash_addr, // word address pins
  input wire logic [15:0] dq_in, // data pins, inbound
  output logic [15:0] dq_out, // data pins, outbound
  output logic dq_oe, // data pin drive enable
  output logic wait_out, // wait pin
  output logic [`NFC_ADDR_W-3:0] page_addr, // array page being sensed
  input wire logic [63:0] page_data, // four words of that page
  output logic op_start, // one-cycle start of an operation
  output logic [2:0] op_kind, // erase, program or protection
  output logic [`NFC_ADDR_W-1:0] op_addr, // operation address
  output logic [15:0] op_data // operation data
);
  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  nfc_pkg::nfc_state_t q; // registered state
  nfc_pkg::nfc_state_t n; // next state
  nfc_pkg::nfc_pins_t pins_in; // raw pins
  logic we_rise; // write strobe ended with chip enabled
  logic adv_rise; // address valid released
  logic clk_rise; // burst clock rising
  logic [7:0] code; // command byte
  logic [`NFC_ADDR_W-1:0] wa; // sampled address
  logic [`NFC_BLK_W-1:0] blk; // addressed block
  logic [7:0] sr; // status bits
  logic req; // avalon request present
  logic [15:0] wa16; // address lines 15:0

  // words in a burst, zero means continuous
  function automatic logic [4:0] burst_words(input logic [2:0] bl);
    case (bl)
      `NFC_BL_4: burst_words = 5'h04;
      `NFC_BL_8: burst_words = 5'h08;
      `NFC_BL_16: burst_words = 5'h10;
      default: burst_words = 5'h00; // continuous or reserved
    endcase
  endfunction

  // next burst address, wrapping inside the burst when asked
  function automatic logic [`NFC_ADDR_W-1:0] next_addr(input logic [`NFC_ADDR_W-1:0] a,
                                                       input logic [2:0] bl, input logic nowrap);
    logic [4:0] w;
    logic [`NFC_ADDR_W-1:0] m;
    w = burst_words(bl);
    m = {15'h0000, 5'(w - 5'h01)};
    if (nowrap || w == 5'h00) begin
      next_addr = a + 20'h00001;
    end else begin
      next_addr = (a & ~m) | ((a + 20'h00001) & m);
    end
  endfunction

  // word shown on the data pins for a read state and address
  function automatic logic [15:0] read_word(input nfc_pkg::nfc_rdstate_t rs,
                                            input logic [`NFC_ADDR_W-1:0] a,
                                            input logic [63:0] pg, input logic [7:0] s,
                                            input logic [15:0] rc, input logic [`NFC_NBLK-1:0] lk,
                                            input logic [`NFC_NBLK-1:0] ld);
    logic [`NFC_BLK_W-1:0] b;
    b = a[`NFC_ADDR_W-1 -: `NFC_BLK_W];
    case (rs)
      nfc_pkg::NFC_RD_ARRAY: read_word = pg[{a[1:0], 4'h0} +: 16];
      nfc_pkg::NFC_RD_STATUS: read_word = {8'h00, s};
      nfc_pkg::NFC_RD_ID: begin
        case (a[7:0])
          `NFC_ID_MFR: read_word = MFR_CODE;
          `NFC_ID_DEV: read_word = DEV_CODE;
          `NFC_ID_LOCK: read_word = {14'h0000, ld[b], lk[b]};
          `NFC_ID_RCR: read_word = rc;
          default: read_word = 16'h0000;
        endcase
      end
      nfc_pkg::NFC_RD_QUERY: read_word = {8'h00, QUERY_BYTE};
      default: read_word = 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // decode of sampled pins
  // ----------------------------------------------------------------
  assign pins_in = '{ce_n: flash_ce_n, oe_n: flash_oe_n, we_n: flash_we_n, adv_n: address_valid_n,
                     clk: flash_clk, addr: flash_addr, dq: dq_in};
  assign we_rise = q.s2.we_n & ~q.we_p & ~q.s2.ce_n;
  assign adv_rise = q.s2.adv_n & ~q.adv_p & ~q.s2.ce_n;
  assign clk_rise = q.s2.clk & ~q.clk_p;
  assign code = q.s2.dq[7:0];
  assign wa = q.s2.addr;
  assign wa16 = wa[15:0];
  assign blk = wa[`NFC_ADDR_W-1 -: `NFC_BLK_W];
  assign sr = {q.write_state_machine != nfc_pkg::NFC_W_BUSY, q.esus, q.err5, q.err4, 1'b0, q.psus, 2'b00};
  assign req = avs_read | avs_write;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic go; // start an operation
    nfc_pkg::nfc_op_t go_kind; // kind to start
    go = 1'b0;
    go_kind = nfc_pkg::NFC_OP_ERASE;
    n = q;
    // two-flop pin synchroniser, then edge history
    n.s1 = pins_in;
    n.s2 = q.s1;
    n.we_p = q.s2.we_n;
    n.adv_p = q.s2.adv_n;
    n.clk_p = q.s2.clk;
    n.op_start = 1'b0;
    n.ack = 1'b0;
    // operation countdown; suspend freezes it
    if (q.write_state_machine == nfc_pkg::NFC_W_BUSY) begin
      if (q.cnt <= 16'h0001) begin
        n.write_state_machine = nfc_pkg::NFC_W_READY;
        n.cnt = 16'h0000;
      end else begin
        n.cnt = q.cnt - 16'h0001;
      end
    end
    // command interface
    if (we_rise) begin
      if (q.write_state_machine == nfc_pkg::NFC_W_BUSY) begin
        // busy: only status read and suspend
        if (code == `NFC_CMD_RD_STATUS) begin
          n.rd = nfc_pkg::NFC_RD_STATUS;
        end else if (code == `NFC_CMD_SUSPEND && q.kind != nfc_pkg::NFC_OP_PROT) begin
          n.write_state_machine = nfc_pkg::NFC_W_SUSP;
          n.esus = q.kind == nfc_pkg::NFC_OP_ERASE;
          n.psus = q.kind == nfc_pkg::NFC_OP_PROG;
        end
      end else if (q.pend != nfc_pkg::NFC_PD_NONE) begin
        // second cycle, meaning set by the pending first cycle
        n.pend = nfc_pkg::NFC_PD_NONE;
        case (q.pend)
          nfc_pkg::NFC_PD_ERASE: begin
            if (code == `NFC_CMD_CONFIRM) begin
              go = 1'b1;
              go_kind = nfc_pkg::NFC_OP_ERASE;
            end else begin
              n.err4 = 1'b1;
              n.err5 = 1'b1;
              n.rd = nfc_pkg::NFC_RD_STATUS;
            end
          end
          nfc_pkg::NFC_PD_PROG: begin
            go = 1'b1;
            go_kind = nfc_pkg::NFC_OP_PROG;
          end
          nfc_pkg::NFC_PD_PROT: begin
            go = 1'b1;
            go_kind = nfc_pkg::NFC_OP_PROT;
          end
          nfc_pkg::NFC_PD_LOCKCFG: begin
            case (code)
              `NFC_CMD_LOCK: n.lock[blk] = 1'b1;
              `NFC_CMD_LOCKDOWN: begin
                n.lock[blk] = 1'b1;
                n.ldown[blk] = 1'b1;
              end
              `NFC_CMD_CONFIRM: begin
                if (!q.ldown[blk]) begin
                  n.lock[blk] = 1'b0;
                end
              end
              `NFC_CMD_CFG: begin
                n.read_config_register = wa16;
                n.rd = nfc_pkg::NFC_RD_ARRAY;
              end
              default: begin
                n.err4 = 1'b1;
                n.err5 = 1'b1;
              end
            endcase
          end
          default: ;
        endcase
      end else begin
        // first cycle
        case (code)
          `NFC_CMD_RD_ARRAY: n.rd = nfc_pkg::NFC_RD_ARRAY;
          `NFC_CMD_RD_STATUS: n.rd = nfc_pkg::NFC_RD_STATUS;
          `NFC_CMD_RD_ID: n.rd = nfc_pkg::NFC_RD_ID;
          `NFC_CMD_RD_QUERY: n.rd = nfc_pkg::NFC_RD_QUERY;
          `NFC_CMD_CLR_STATUS: begin
            n.err4 = 1'b0;
            n.err5 = 1'b0;
          end
          `NFC_CMD_CONFIRM: begin
            if (q.write_state_machine == nfc_pkg::NFC_W_SUSP) begin
              n.write_state_machine = nfc_pkg::NFC_W_BUSY;
              n.esus = 1'b0;
              n.psus = 1'b0;
            end
          end
          `NFC_CMD_ERASE: if (q.write_state_machine == nfc_pkg::NFC_W_READY) n.pend = nfc_pkg::NFC_PD_ERASE;
          `NFC_CMD_PROG: if (q.write_state_machine == nfc_pkg::NFC_W_READY) n.pend = nfc_pkg::NFC_PD_PROG;
          `NFC_CMD_PROG_ALT: if (q.write_state_machine == nfc_pkg::NFC_W_READY) n.pend = nfc_pkg::NFC_PD_PROG;
          `NFC_CMD_LOCK_SETUP: if (q.write_state_machine == nfc_pkg::NFC_W_READY) n.pend = nfc_pkg::NFC_PD_LOCKCFG;
          `NFC_CMD_PROT: if (q.write_state_machine == nfc_pkg::NFC_W_READY) n.pend = nfc_pkg::NFC_PD_PROT;
          default: ; // unknown codes ignored
        endcase
      end
    end
    // launch of an operation
    if (go) begin
      n.write_state_machine = nfc_pkg::NFC_W_BUSY;
      n.kind = go_kind;
      n.cnt = q.opcyc;
      n.rd = nfc_pkg::NFC_RD_STATUS;
      n.op_start = 1'b1;
      n.op_addr = wa;
      n.op_data = q.s2.dq;
    end
    // read path
    n.dq_oe = ~q.s2.ce_n & ~q.s2.oe_n & q.s2.we_n;
    if (q.read_config_register[`NFC_RCR_RM]) begin
      // async page mode: clock ignored, address transparent while valid low
      n.sync_act = 1'b0;
      n.lat_cnt = 3'h0;
      if (!q.s2.adv_n) begin
        n.lat_addr = wa;
      end
      n.dq = read_word(q.rd, q.lat_addr, page_data, sr, q.read_config_register, q.lock, q.ldown);
      n.wait_q = ~q.read_config_register[`NFC_RCR_WP];
    end else begin
      // sync burst mode
      if (q.s2.ce_n) begin
        n.sync_act = 1'b0;
      end else if (!q.sync_act && (adv_rise || (clk_rise && !q.s2.adv_n))) begin
        n.sync_act = 1'b1;
        n.lat_addr = wa;
        n.lat_cnt = (q.read_config_register[13:11] == 3'h0) ? 3'h1 : q.read_config_register[13:11];
        n.left = burst_words(q.read_config_register[2:0]);
        n.cont = burst_words(q.read_config_register[2:0]) == 5'h00;
      end else if (q.sync_act && clk_rise) begin
        if (q.lat_cnt > 3'h1) begin
          n.lat_cnt = q.lat_cnt - 3'h1;
        end else if (q.lat_cnt == 3'h1 || q.cont || q.left != 5'h00) begin
          n.lat_cnt = 3'h0;
          n.dq = read_word(q.rd, q.lat_addr, page_data, sr, q.read_config_register, q.lock, q.ldown);
          if (!q.cont) begin
            n.left = q.left - 5'h01;
          end
          if (q.rd == nfc_pkg::NFC_RD_ARRAY) begin
            n.lat_addr = next_addr(q.lat_addr, q.read_config_register[2:0], q.read_config_register[`NFC_RCR_BW]);
          end
        end
      end
      n.wait_q = (q.sync_act && q.lat_cnt != 3'h0) ? q.read_config_register[`NFC_RCR_WP] : ~q.read_config_register[`NFC_RCR_WP];
    end
    // avalon slave: answer one cycle after the request, commit a write when waitrequest is low
    if (avs_write && q.ack && avs_address == `NFC_REG_OPCYC) begin
      if (avs_byteenable[0]) n.opcyc[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1]) n.opcyc[15:8] = avs_writedata[15:8];
    end
    if (req && !q.ack) begin
      n.ack = 1'b1;
      case (avs_address)
        `NFC_REG_STATUS: n.rdata = {16'h0000, 1'b0, q.write_state_machine, q.rd, sr};
        `NFC_REG_RCR: n.rdata = {16'h0000, q.read_config_register};
        `NFC_REG_OPCYC: n.rdata = {16'h0000, q.opcyc};
        `NFC_REG_LOCK: n.rdata = {16'h0000, q.ldown, q.lock};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.s1 <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1, clk: 1'b0, addr: 20'h00000, dq: 16'h0000};
      q.s2 <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1, clk: 1'b0, addr: 20'h00000, dq: 16'h0000};
      q.we_p <= 1'b1;
      q.adv_p <= 1'b1;
      q.rd <= nfc_pkg::NFC_RD_ARRAY;
      q.pend <= nfc_pkg::NFC_PD_NONE;
      q.write_state_machine <= nfc_pkg::NFC_W_READY;
      q.kind <= nfc_pkg::NFC_OP_ERASE;
      q.read_config_register <= `NFC_RCR_RST;
      q.opcyc <= `NFC_OPCYC_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = req & ~q.ack;
  assign avs_readdata = q.rdata;
  assign dq_out = q.dq;
  assign dq_oe = q.dq_oe;
  assign wait_out = q.wait_q;
  assign page_addr = q.lat_addr[`NFC_ADDR_W-1:2];
  assign op_start = q.op_start;
  assign op_kind = q.kind;
  assign op_addr = q.op_addr;
  assign op_data = q.op_data;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  erase_confirm_a: assert property (we_rise && q.write_state_machine == nfc_pkg::NFC_W_READY &&
    q.pend == nfc_pkg::NFC_PD_ERASE && code == `NFC_CMD_CONFIRM
    |=> q.write_state_machine == nfc_pkg::NFC_W_BUSY && q.kind == nfc_pkg::NFC_OP_ERASE && op_start ##1 !op_start)
    else $error("erase confirm did not start erase");
  erase_seq_err_a: assert property (we_rise && q.write_state_machine == nfc_pkg::NFC_W_READY &&
    q.pend == nfc_pkg::NFC_PD_ERASE && code != `NFC_CMD_CONFIRM
    |=> sr[5] && sr[4] && q.rd == nfc_pkg::NFC_RD_STATUS && q.write_state_machine == nfc_pkg::NFC_W_READY)
    else $error("bad erase confirm not flagged");
  busy_ignore_a: assert property (we_rise && q.write_state_machine == nfc_pkg::NFC_W_BUSY && q.cnt > 16'h0001 &&
    code != `NFC_CMD_RD_STATUS && code != `NFC_CMD_SUSPEND
    |=> q.rd == $past(q.rd) && q.pend == $past(q.pend) && q.read_config_register == $past(q.read_config_register) && q.write_state_machine == nfc_pkg::NFC_W_BUSY)
    else $error("command taken while busy");
  suspend_a: assert property (we_rise && q.write_state_machine == nfc_pkg::NFC_W_BUSY && q.kind == nfc_pkg::NFC_OP_ERASE &&
    code == `NFC_CMD_SUSPEND |=> q.write_state_machine == nfc_pkg::NFC_W_SUSP && sr[6] && sr[7] && !sr[2])
    else $error("erase suspend not reported");
  susp_hold_a: assert property (q.write_state_machine == nfc_pkg::NFC_W_SUSP &&
    !(we_rise && q.pend == nfc_pkg::NFC_PD_NONE && code == `NFC_CMD_CONFIRM)
    |=> q.write_state_machine == nfc_pkg::NFC_W_SUSP && q.cnt == $past(q.cnt))
    else $error("suspend left without resume");
  resume_a: assert property (we_rise && q.write_state_machine == nfc_pkg::NFC_W_SUSP && q.pend == nfc_pkg::NFC_PD_NONE &&
    code == `NFC_CMD_CONFIRM |=> q.write_state_machine == nfc_pkg::NFC_W_BUSY && !sr[7] && !sr[6] && !sr[2])
    else $error("resume did not restart operation");
  lock_seq_err_a: assert property (we_rise && q.write_state_machine != nfc_pkg::NFC_W_BUSY &&
    q.pend == nfc_pkg::NFC_PD_LOCKCFG && !(code inside {`NFC_CMD_LOCK, `NFC_CMD_CONFIRM,
    `NFC_CMD_LOCKDOWN, `NFC_CMD_CFG}) |=> sr[4] && sr[5] && q.lock == $past(q.lock))
    else $error("bad lock sequence not flagged");
  lockdown_keep_a: assert property (we_rise && q.write_state_machine != nfc_pkg::NFC_W_BUSY &&
    q.pend == nfc_pkg::NFC_PD_LOCKCFG && code == `NFC_CMD_CONFIRM && q.ldown[blk]
    |=> q.lock == $past(q.lock))
    else $error("locked-down block was unlocked");
  cfg_load_a: assert property (we_rise && q.write_state_machine != nfc_pkg::NFC_W_BUSY &&
    q.pend == nfc_pkg::NFC_PD_LOCKCFG && code == `NFC_CMD_CFG
    |=> q.read_config_register == $past(wa16) && q.rd == nfc_pkg::NFC_RD_ARRAY)
    else $error("config load wrong");
  async_wait_a: assert property (q.read_config_register[`NFC_RCR_RM] && $stable(q.read_config_register) |=>
    wait_out == ~$past(q.read_config_register[`NFC_RCR_WP]) && !q.sync_act)
    else $error("wait asserted in async mode");

  erase_cover_c: cover property (q.write_state_machine == nfc_pkg::NFC_W_BUSY && q.kind == nfc_pkg::NFC_OP_ERASE
    ##1 q.write_state_machine == nfc_pkg::NFC_W_READY);
  susp_cover_c: cover property (q.write_state_machine == nfc_pkg::NFC_W_SUSP ##1 q.write_state_machine == nfc_pkg::NFC_W_BUSY);
  cfg_cover_c: cover property (!q.read_config_register[`NFC_RCR_RM] && q.sync_act);
  burst_cover_c: cover property (q.sync_act && q.lat_cnt == 3'h1 && clk_rise ##1 q.lat_cnt == 3'h0);
endmodule

// [nfc_params.svh]
`ifndef NFC_PARAMS_SVH
`define NFC_PARAMS_SVH
// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define NFC_ADDR_W 20
`define NFC_NBLK 8
`define NFC_BLK_W 3
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define NFC_CMD_ERASE 8'h20
`define NFC_CMD_CONFIRM 8'hd0
`define NFC_CMD_SUSPEND 8'hb0
`define NFC_CMD_LOCK_SETUP 8'h60
`define NFC_CMD_LOCK 8'h01
`define NFC_CMD_LOCKDOWN 8'h2f
`define NFC_CMD_CFG 8'h03
`define NFC_CMD_PROT 8'hc0
`define NFC_CMD_PROG 8'h40
`define NFC_CMD_PROG_ALT 8'h10
`define NFC_CMD_RD_ARRAY 8'hff
`define NFC_CMD_RD_STATUS 8'h70
`define NFC_CMD_RD_ID 8'h90
`define NFC_CMD_RD_QUERY 8'h98
`define NFC_CMD_CLR_STATUS 8'h50
// ----------------------------------------------------------------
// read config field positions, burst codes, id offsets, reset value
// ----------------------------------------------------------------
`define NFC_RCR_RM 15
`define NFC_RCR_WP 10
`define NFC_RCR_BW 3
`define NFC_RCR_RST 16'hbfcf
`define NFC_BL_4 3'h1
`define NFC_BL_8 3'h2
`define NFC_BL_16 3'h3
`define NFC_ID_MFR 8'h00
`define NFC_ID_DEV 8'h01
`define NFC_ID_LOCK 8'h02
`define NFC_ID_RCR 8'h05
// ----------------------------------------------------------------
// avalon register byte offsets
// ----------------------------------------------------------------
`define NFC_REG_STATUS 4'h0
`define NFC_REG_RCR 4'h4
`define NFC_REG_OPCYC 4'h8
`define NFC_REG_LOCK 4'hc
`define NFC_OPCYC_RST 16'h0040
`endif

// [nfc_pkg.sv]
`include "nfc_params.svh"
package nfc_pkg;
  // read state, one-hot
  typedef enum logic [3:0] {NFC_RD_ARRAY = 4'h1, NFC_RD_ID = 4'h2, NFC_RD_STATUS = 4'h4,
                            NFC_RD_QUERY = 4'h8} nfc_rdstate_t;
  // first-cycle command awaiting its second cycle
  typedef enum logic [4:0] {NFC_PD_NONE = 5'h01, NFC_PD_ERASE = 5'h02, NFC_PD_PROG = 5'h04,
                            NFC_PD_LOCKCFG = 5'h08, NFC_PD_PROT = 5'h10} nfc_pend_t;
  // write state machine
  typedef enum logic [2:0] {NFC_W_READY = 3'h1, NFC_W_BUSY = 3'h2, NFC_W_SUSP = 3'h4} nfc_wsm_t;
  // operation kind
  typedef enum logic [2:0] {NFC_OP_ERASE = 3'h1, NFC_OP_PROG = 3'h2, NFC_OP_PROT = 3'h4} nfc_op_t;
  // pin bundle as sampled
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic adv_n;
    logic clk;
    logic [`NFC_ADDR_W-1:0] addr;
    logic [15:0] dq;
  } nfc_pins_t;
  // complete state of the block
  typedef struct packed {
    nfc_pins_t s1;
    nfc_pins_t s2;
    logic we_p;
    logic adv_p;
    logic clk_p;
    nfc_rdstate_t rd;
    nfc_pend_t pend;
    nfc_wsm_t write_state_machine;
    nfc_op_t kind;
    logic [15:0] cnt;
    logic err4;
    logic err5;
    logic psus;
    logic esus;
    logic [15:0] read_config_register;
    logic [`NFC_NBLK-1:0] lock;
    logic [`NFC_NBLK-1:0] ldown;
    logic [`NFC_ADDR_W-1:0] lat_addr;
    logic sync_act;
    logic [2:0] lat_cnt;
    logic [4:0] left;
    logic cont;
    logic [15:0] dq;
    logic dq_oe;
    logic wait_q;
    logic op_start;
    logic [`NFC_ADDR_W-1:0] op_addr;
    logic [15:0] op_data;
    logic [15:0] opcyc;
    logic ack;
    logic [31:0] rdata;
  } nfc_state_t;
endpackage

// [nfc_host_model.sv]
`include "nfc_params.svh"
// ----------------------------------------
// host side pin driver
// ----------------------------------------
module nfc_host_model (
  input wire logic clk, // pacing clock
  output logic ce_n, // chip enable
  output logic oe_n, // output enable
  output logic we_n, // write enable
  output logic adv_n, // address valid
  output logic fclk, // burst clock, idle low
  output logic [`NFC_ADDR_W-1:0] addr, // address pins
  output logic [15:0] dq // data, inverted once released
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ce_n, oe_n, we_n, adv_n, fclk, addr, dq} = {5'h1e, 36'h0};
  // one command cycle, each level held four clocks
  task automatic wr(input logic [7:0] c, input logic [`NFC_ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    dq <= {8'h00, c};
    {ce_n, oe_n, we_n} <= 3'h2; // output enable held off while writing
    repeat (4) @(posedge clk);
    we_n <= 1'b1;
    repeat (4) @(posedge clk);
    ce_n <= 1'b1;
    dq <= ~{8'h00, c};
    repeat (4) @(posedge clk);
  endtask
  // ce toggles high first, we stays high, then address with ce, oe, adv low
  task automatic rd(input logic [`NFC_ADDR_W-1:0] a);
    {ce_n, oe_n, adv_n} <= 3'h7;
    repeat (4) @(posedge clk);
    addr <= a;
    {ce_n, oe_n, adv_n} <= 3'h0;
    repeat (8) @(posedge clk);
  endtask
  // adv and burst clock levels, 80 ns each, so fclk runs at 160 ns
  task automatic step(input logic [1:0] v);
    {adv_n, fclk} <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

// [tb_top.sv]
`include "nfc_params.svh"
// ----------------------------------------
// bench for the command and read block
// ----------------------------------------
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MFR = 16'h3c3c; // arbitrary value
  logic core_clk = 1'b0; // 50 MHz clock
  logic rstn = 1'b0; // reset, active low
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, dq_oe, wait_out, op_start; // strobes, flags
  logic [3:0] avs_address = 4'h0; // register offset
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q; // bus data, last read
  logic h_ce, h_oe, h_we, h_adv, h_clk; // host pins
  logic [`NFC_ADDR_W-1:0] h_addr, op_addr, base; // addresses
  logic [15:0] h_dq, dq_in, dq_out, op_data; // data words
  logic [17:0] page_addr; // page sensed
  logic [63:0] page_data; // word k holds page bits and k
  logic [2:0] op_kind; // one-hot kind
  logic [7:0] cs [5] = '{8'h01, 8'h2f, 8'hd0, 8'h01, 8'hd0}; // lock codes
  int error_cnt = 0, checks = 0, seed = 84971, starts = 0, lk = 0, ld = 0, b; // counters, lock model
  int bq [$]; // expected burst words
  assign page_data = {page_addr[13:0], 2'h3, page_addr[13:0], 2'h2, page_addr[13:0], 2'h1, page_addr[13:0], 2'h0};
  assign dq_in = dq_oe ? dq_out : h_dq; // wire level
  initial forever #10 core_clk = ~core_clk;
  // count start pulses
  always @(posedge core_clk) starts <= starts + (op_start === 1'b1);
  nfc_host_model u_nfc_host_model (.clk(core_clk), .ce_n(h_ce), .oe_n(h_oe), .we_n(h_we), .adv_n(h_adv),
    .fclk(h_clk), .addr(h_addr), .dq(h_dq));
  nfc_cmd_read #(.MFR_CODE(MFR), .QUERY_BYTE(8'h69)) u_nfc_cmd_read (.core_clk, .rstn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .flash_ce_n(h_ce), .flash_oe_n(h_oe),
    .flash_we_n(h_we), .address_valid_n(h_adv), .flash_clk(h_clk), .flash_addr(h_addr), .dq_in, .dq_out, .dq_oe,
    .wait_out, .page_addr, .page_data, .op_start, .op_kind, .op_addr, .op_data);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic st(input int ws, input int rs, input int sb);
    av(1'b0, `NFC_REG_STATUS, 32'h0);
    chk("status", (ws << 12) | (rs << 8) | sb, q);
  endtask
  task automatic w(input logic [7:0] c, input logic [`NFC_ADDR_W-1:0] a);
    u_nfc_host_model.wr(c, a);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    st(1, 1, 'h80);
    av(1'b0, `NFC_REG_RCR, 32'h0);
    chk("rcr", 32'hbfcf, q);
    av(1'b1, `NFC_REG_OPCYC, 32'h400);
    base = 20'($random(seed)) & 20'hffffc;
    for (int k = 0; k < 4; k++) begin
      u_nfc_host_model.rd(base + 20'(k));
      chk("page", base[15:0] + k, dq_out);
      chk("wait", 32'h0, wait_out);
      chk("oe", 32'h1, dq_oe);
    end
    w(8'h90, 20'h0);
    u_nfc_host_model.rd(20'h0);
    chk("ident", MFR, dq_out);
    w(8'h98, 20'h0);
    u_nfc_host_model.rd(20'h0);
    chk("query", 32'h69, dq_out);
    w(8'hff, 20'h0);
    st(1, 1, 'h80);
    w(8'h20, 20'h40000);
    w(8'hd0, 20'h40010);
    chk("start", 32'h1, starts);
    chk("opaddr", 32'h40010, op_addr);
    st(2, 4, 'h00);
    w(8'hff, 20'h0);
    st(2, 4, 'h00);
    w(8'hb0, 20'h0);
    st(4, 4, 'hc0);
    w(8'h20, 20'h0);
    st(4, 4, 'hc0);
    w(8'hd0, 20'h0);
    st(2, 4, 'h00);
    repeat (1100) @(posedge core_clk);
    w(8'hff, 20'h0);
    w(8'h20, 20'h0);
    w(8'h55, 20'h0);
    st(1, 4, 'hb0);
    w(8'h50, 20'h0);
    for (int i = 0; i < 5; i++) begin
      b = i < 3 ? 2 : 5;
      w(8'h60, 20'h0);
      w(cs[i], 20'(b << 17));
      if (cs[i] == 8'h01 || cs[i] == 8'h2f) lk |= 1 << b;
      if (cs[i] == 8'h2f) ld |= 1 << b;
      if (cs[i] == 8'hd0 && !ld[b]) lk &= ~(1 << b);
      av(1'b0, `NFC_REG_LOCK, 32'h0);
      chk("lock", (ld << 8) | lk, q);
    end
    w(8'h60, 20'h0);
    w(8'h55, 20'h0);
    st(1, 4, 'hb0);
    w(8'h50, 20'h0);
    w(8'h40, 20'h0);
    w(8'h3c, 20'h0);
    w(8'hb0, 20'h0);
    st(4, 4, 'h84);
    w(8'hd0, 20'h0);
    repeat (1100) @(posedge core_clk);
    av(1'b1, `NFC_REG_OPCYC, 32'h4);
    w(8'hc0, 20'h0);
    w(8'h5a, 20'h00080);
    chk("kind", 32'h4, op_kind);
    chk("opdata", 32'h5a, op_data);
    w(8'h60, 20'h01c01);
    w(8'h03, 20'h01c01);
    st(1, 1, 'h80);
    av(1'b0, `NFC_REG_RCR, 32'h0);
    chk("rcr", 32'h1c01, q);
    base = (20'($random(seed)) & 20'hffffc) | 20'h1;
    for (int i = 0; i < 4; i++) bq.push_back({base[15:2], 2'(base[1:0] + i)});
    u_nfc_host_model.rd(base);
    u_nfc_host_model.step(2'h2);
    for (int i = 1; i < 8; i++) begin
      u_nfc_host_model.step(2'h3);
      u_nfc_host_model.step(2'h2);
      chk("waitpin", i < 3, wait_out);
      if (i >= 3) chk("burst", bq[i > 6 ? 3 : i - 3], dq_out);
    end
    w(8'h90, 20'h0);
    u_nfc_host_model.rd(20'h0);
    u_nfc_host_model.step(2'h2);
    for (int i = 1; i < 6; i++) begin
      u_nfc_host_model.step(2'h3);
      u_nfc_host_model.step(2'h2);
      if (i >= 3) chk("nonarray", MFR, dq_out);
    end
    summarize();
  end
  // watchdog
  initial begin
    #400us;
    error_cnt++;
    summarize();
  end
endmodule
